//--- logic/tpc_timer_pins.sv
// timer counter with capture, compare and pwm channel pin control
// assumes pins are resolved outside from CH_OUT and CH_OE, and that
// the general purpose port owns a pin while CH_OWN is low
import tpc_pkg::*;

module tpc_timer_pins (
   input  wire logic                     CLOCK,
   input  wire logic                     RST_N,
   input  wire logic [tpc_pkg::AW-1:0]   ADDR,
   input  wire logic [tpc_pkg::DW-1:0]   WDATA,
   input  wire logic                     WR,
   input  wire logic                     RD,
   output logic      [tpc_pkg::DW-1:0]   RDATA,
   input  wire logic                     FIXED_TICK,
   input  wire logic                     EXT_CLK,
   input  wire logic [tpc_pkg::NCH-1:0]  CH_IN,
   output logic      [tpc_pkg::NCH-1:0]  CH_OUT,
   output logic      [tpc_pkg::NCH-1:0]  CH_OE,
   output logic      [tpc_pkg::NCH-1:0]  CH_OWN,
   output logic                          OVERFLOW
);
   import tpc_pkg::*;

   typedef struct packed {
      logic                      ovf;
      logic                      ovf_arm;
      logic                      cpwm;
      logic [1:0]                clks;
      logic [2:0]                ps;
      logic                      up;
      logic [DW-1:0]             cnt;
      logic [DW-1:0]             modv;
      logic [PRE_W-1:0]          pre;
      logic [NCH-1:0][1:0]       mode;
      logic [NCH-1:0][1:0]       els;
      logic [NCH-1:0][DW-1:0]    cv;
      logic [NCH-1:0]            flag;
      logic [NCH-1:0]            arm;
      logic [NCH-1:0]            out;
      logic [NCH-1:0]            oe;
      logic [NCH-1:0]            own;
      logic [DW-1:0]             rdata;
   } tpc_state_t;

   tpc_state_t r_ff;
   tpc_state_t nxt_r;

   logic [NCH:0]       sync_rise;
   logic [NCH:0]       sync_fall;
   logic               src;
   logic               tick;
   logic [PRE_W-1:0]   pmask;
   logic [DW-1:0]      top;
   logic [NCH-1:0]     match;
   logic [NCH-1:0]     set_flag;
   logic               set_ovf;

   // ---------------------------------------------------------------
   // pin synchronisers: bit 0 external clock, then channel inputs
   // ---------------------------------------------------------------
   tpc_sync #(
      .W (NCH + 1)
   ) u_sync (
      .CLOCK (CLOCK),
      .RST_N (RST_N),
      .PIN   ({CH_IN, EXT_CLK}),
      .LEVEL (),
      .RISE  (sync_rise),
      .FALL  (sync_fall)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_r    = r_ff;
      set_ovf  = 1'b0;
      set_flag = '0;
      match    = '0;
      nxt_r.rdata = '0;

      // only rising edges of the filtered input count
      case (r_ff.clks)
         CLK_BUS:   src = 1'b1;
         CLK_FIXED: src = FIXED_TICK;
         CLK_EXT:   src = sync_rise[0];
         default:   src = 1'b0;
      endcase

      pmask = PRE_W'((8'h01 << r_ff.ps) - 8'h01);
      tick  = src && ((r_ff.pre & pmask) == pmask);
      if (src)
         nxt_r.pre = r_ff.pre + 7'h01;

      // modulo 0 counts over the full range
      top = (r_ff.modv == MOD_RST) ? CNT_TOP : r_ff.modv;

      // -------------------------------------------------------------
      // counter
      // -------------------------------------------------------------
      if (tick)
      begin
         if (r_ff.cpwm)
         begin
            if (r_ff.up)
            begin
               if (r_ff.cnt >= top)
               begin
                  nxt_r.up  = 1'b0;
                  nxt_r.cnt = r_ff.cnt - 16'h0001;
               end
               else
                  nxt_r.cnt = r_ff.cnt + 16'h0001;
            end
            else
            begin
               nxt_r.cnt = r_ff.cnt - 16'h0001;
               if (r_ff.cnt == 16'h0001)
               begin
                  nxt_r.up = 1'b1;
                  set_ovf  = 1'b1;
               end
            end
         end
         else
         begin
            nxt_r.up = 1'b1;
            if (r_ff.cnt >= top)
            begin
               nxt_r.cnt = CNT_RST;
               set_ovf   = 1'b1;
            end
            else
               nxt_r.cnt = r_ff.cnt + 16'h0001;
         end
      end

      // -------------------------------------------------------------
      // channels
      // -------------------------------------------------------------
      for (int i = 0; i < NCH; i++)
      begin
         match[i] = tick && (nxt_r.cnt == r_ff.cv[i]);
         // pin ownership needs a running source and an edge select
         nxt_r.own[i] = (r_ff.clks != CLK_NONE) &&
                        (r_ff.els[i] != ELS_OFF);
         nxt_r.oe[i]  = nxt_r.own[i] &&
                        (r_ff.cpwm || r_ff.mode[i] != MODE_CAP);
         if (r_ff.cpwm)
         begin
            if (match[i])
            begin
               set_flag[i] = 1'b1;
               if (nxt_r.own[i])
                  nxt_r.out[i] = r_ff.up ? r_ff.els[i][0]
                                         : ~r_ff.els[i][0];
            end
         end
         else if (r_ff.mode[i] == MODE_CAP)
         begin
            if (nxt_r.own[i] &&
                ((r_ff.els[i][0] && sync_rise[i+1]) ||
                 (r_ff.els[i][1] && sync_fall[i+1])))
            begin
               nxt_r.cv[i] = r_ff.cnt;
               set_flag[i] = 1'b1;
            end
         end
         else if (r_ff.mode[i] == MODE_CMP)
         begin
            if (match[i])
            begin
               set_flag[i] = 1'b1;
               case (r_ff.els[i])
                  ELS_TOG: nxt_r.out[i] = ~r_ff.out[i];
                  ELS_CLR: nxt_r.out[i] = 1'b0;
                  ELS_SET: nxt_r.out[i] = 1'b1;
                  default: nxt_r.out[i] = r_ff.out[i];
               endcase
            end
         end
         else
         begin
            if (nxt_r.own[i])
            begin
               if (tick && nxt_r.cnt == CNT_RST)
                  nxt_r.out[i] = ~r_ff.els[i][0];
               if (match[i])
                  nxt_r.out[i] = r_ff.els[i][0];
            end
            if (match[i])
               set_flag[i] = 1'b1;
         end
      end

      // -------------------------------------------------------------
      // register reads: a read of a set flag arms its clear
      // -------------------------------------------------------------
      if (RD)
      begin
         if (ADDR == ADR_SC)
         begin
            nxt_r.rdata[SC_OVF_BIT]  = r_ff.ovf;
            nxt_r.rdata[SC_CPWM_BIT] = r_ff.cpwm;
            nxt_r.rdata[SC_CLKS_LSB +: 2] = r_ff.clks;
            nxt_r.rdata[SC_PS_LSB +: 3]   = r_ff.ps;
            if (r_ff.ovf)
               nxt_r.ovf_arm = 1'b1;
         end
         if (ADDR == ADR_CNT)
            nxt_r.rdata = r_ff.cnt;
         if (ADDR == ADR_MOD)
            nxt_r.rdata = r_ff.modv;
         for (int i = 0; i < NCH; i++)
         begin
            if (ADDR == AW'(ADR_CH0 + CH_STEP * i))
            begin
               nxt_r.rdata[CS_FLAG_BIT]      = r_ff.flag[i];
               nxt_r.rdata[CS_MODE_LSB +: 2] = r_ff.mode[i];
               nxt_r.rdata[CS_ELS_LSB +: 2]  = r_ff.els[i];
               if (r_ff.flag[i])
                  nxt_r.arm[i] = 1'b1;
            end
            if (ADDR == AW'(ADR_CH0 + CH_STEP * i + 1))
               nxt_r.rdata = r_ff.cv[i];
         end
      end

      // -------------------------------------------------------------
      // register writes; a flag set in the clearing cycle survives
      // -------------------------------------------------------------
      if (WR)
      begin
         if (ADDR == ADR_SC)
         begin
            nxt_r.cpwm = WDATA[SC_CPWM_BIT];
            nxt_r.clks = WDATA[SC_CLKS_LSB +: 2];
            nxt_r.ps   = WDATA[SC_PS_LSB +: 3];
            if (!WDATA[SC_OVF_BIT] && r_ff.ovf_arm)
            begin
               nxt_r.ovf     = 1'b0;
               nxt_r.ovf_arm = 1'b0;
            end
         end
         if (ADDR == ADR_CNT)
         begin
            // any write restarts the count whatever the data
            nxt_r.cnt = CNT_RST;
            nxt_r.pre = '0;
            nxt_r.up  = 1'b1;
         end
         if (ADDR == ADR_MOD)
            nxt_r.modv = WDATA;
         for (int i = 0; i < NCH; i++)
         begin
            if (ADDR == AW'(ADR_CH0 + CH_STEP * i))
            begin
               nxt_r.mode[i] = WDATA[CS_MODE_LSB +: 2];
               nxt_r.els[i]  = WDATA[CS_ELS_LSB +: 2];
               if (!WDATA[CS_FLAG_BIT] && r_ff.arm[i])
               begin
                  nxt_r.flag[i] = 1'b0;
                  nxt_r.arm[i]  = 1'b0;
               end
            end
            if (ADDR == AW'(ADR_CH0 + CH_STEP * i + 1))
               nxt_r.cv[i] = WDATA;
         end
      end

      // a fresh event restarts the clear sequence so it is never lost
      if (set_ovf)
      begin
         nxt_r.ovf     = 1'b1;
         nxt_r.ovf_arm = 1'b0;
      end
      for (int i = 0; i < NCH; i++)
      begin
         if (set_flag[i])
         begin
            nxt_r.flag[i] = 1'b1;
            nxt_r.arm[i]  = 1'b0;
         end
      end
   end

   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
         r_ff <= '0;
      else
         r_ff <= nxt_r;
   end

   assign RDATA    = r_ff.rdata;
   assign CH_OUT   = r_ff.out;
   assign CH_OE    = r_ff.oe;
   assign CH_OWN   = r_ff.own;
   assign OVERFLOW = r_ff.ovf;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   AST_NO_CLK_RELEASE: assert property (
      r_ff.clks == CLK_NONE |=> CH_OWN == '0 && CH_OE == '0)
      else $error("pin kept while clock select off");

   AST_ELS_OFF_PIN: assert property (
      r_ff.els[0] == ELS_OFF |=> !CH_OE[0] && !CH_OWN[0])
      else $error("pin driven with edge select off");

   AST_CNT_STOPPED: assert property (
      r_ff.clks == CLK_NONE && !(WR && ADDR == ADR_CNT)
      |=> r_ff.cnt == $past(r_ff.cnt))
      else $error("counter moved with no clock");

   AST_OVF_WRAP: assert property (
      tick && !r_ff.cpwm && r_ff.cnt >= top
      |=> r_ff.cnt == CNT_RST && OVERFLOW)
      else $error("no overflow at modulo wrap");

   AST_EPWM_START: assert property (
      !r_ff.cpwm && r_ff.mode[0][1] && nxt_r.own[0] && tick &&
      nxt_r.cnt == CNT_RST && r_ff.cv[0] != CNT_RST
      |=> CH_OUT[0] == !r_ff.els[0][0])
      else $error("edge pwm period start level wrong");

   AST_EPWM_MATCH: assert property (
      !r_ff.cpwm && r_ff.mode[0][1] && nxt_r.own[0] && match[0]
      |=> CH_OUT[0] == r_ff.els[0][0] && r_ff.flag[0])
      else $error("edge pwm match level wrong");

   AST_CPWM_MATCH: assert property (
      r_ff.cpwm && nxt_r.own[0] && match[0]
      |=> CH_OUT[0] == ($past(r_ff.up) ? r_ff.els[0][0]
                                       : !r_ff.els[0][0]))
      else $error("center pwm match level wrong");

   AST_CPWM_TURN: assert property (
      r_ff.cpwm && tick && r_ff.up && r_ff.cnt >= top
      |=> !r_ff.up ##0 r_ff.cnt == $past(r_ff.cnt) - 16'h0001)
      else $error("center count did not turn at modulo");

   AST_TOGGLE: assert property (
      !r_ff.cpwm && r_ff.mode[0] == MODE_CMP &&
      r_ff.els[0] == ELS_TOG && match[0]
      |=> CH_OUT[0] != $past(CH_OUT[0]))
      else $error("toggle compare did not invert");

   AST_CAPTURE: assert property (
      !r_ff.cpwm && r_ff.mode[0] == MODE_CAP && nxt_r.own[0] &&
      r_ff.els[0] == ELS_TOG && sync_rise[1]
      |=> r_ff.flag[0] && r_ff.cv[0] == $past(r_ff.cnt))
      else $error("rising edge not captured");

   CVR_EPWM:    cover property (!r_ff.cpwm && r_ff.mode[0][1] && match[0]);
   CVR_CPWM:    cover property (r_ff.cpwm && !r_ff.up && match[0]);
   CVR_CAPTURE: cover property (set_flag[0] && r_ff.mode[0] == MODE_CAP);
   CVR_EXTERNAL_COUNT_CLOCK:  cover property (r_ff.clks == CLK_EXT && tick);

endmodule

//--- logic/tpc_pkg.sv
// constants shared by the timer channel pin logic
// assumes one 10 MHz bus clock and a plain strobe register port
package tpc_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int NCH      = 2;
   localparam int AW       = 8;
   localparam int DW       = 16;
   localparam int PRE_W    = 7;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_NS          = 100;
   localparam int EXT_MAX_DIV     = 4;  // source rate at most bus / 4
   localparam int MIN_PULSE_CYC   = 4;  // reliable capture pulse width
   localparam int IDEAL_PULSE_CYC = 2;
   localparam int SYNC_STAGES     = 3;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [AW-1:0] ADR_SC   = 8'h00;
   localparam logic [AW-1:0] ADR_CNT  = 8'h01;
   localparam logic [AW-1:0] ADR_MOD  = 8'h02;
   localparam logic [AW-1:0] ADR_CH0  = 8'h04;
   localparam int            CH_STEP  = 2;   // control, then value

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int SC_OVF_BIT  = 7;
   localparam int SC_CPWM_BIT = 5;
   localparam int SC_CLKS_LSB = 3;
   localparam int SC_PS_LSB   = 0;
   localparam int CS_FLAG_BIT = 7;
   localparam int CS_MODE_LSB = 4;
   localparam int CS_ELS_LSB  = 2;

   // ---------------------------------------------------------------
   // encodings and reset values
   // ---------------------------------------------------------------
   localparam logic [1:0] CLK_NONE  = 2'h0;
   localparam logic [1:0] CLK_BUS   = 2'h1;
   localparam logic [1:0] CLK_FIXED = 2'h2;
   localparam logic [1:0] CLK_EXT   = 2'h3;
   localparam logic [1:0] MODE_CAP  = 2'h0;
   localparam logic [1:0] MODE_CMP  = 2'h1;
   localparam logic [1:0] ELS_OFF   = 2'h0;
   localparam logic [1:0] ELS_TOG   = 2'h1;
   localparam logic [1:0] ELS_CLR   = 2'h2;
   localparam logic [1:0] ELS_SET   = 2'h3;
   localparam logic [DW-1:0] CNT_RST = 16'h0000;
   localparam logic [DW-1:0] CNT_TOP = 16'hFFFF;
   localparam logic [DW-1:0] MOD_RST = 16'h0000;

endpackage

//--- logic/tpc_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
// assumes asynchronous pin levels and the bus clock
module tpc_sync #(
   parameter int W = 1
) (
   input  wire logic         CLOCK,
   input  wire logic         RST_N,
   input  wire logic [W-1:0] PIN,
   output logic      [W-1:0] LEVEL,
   output logic      [W-1:0] RISE,
   output logic      [W-1:0] FALL
);
   import tpc_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
      logic [W-1:0] rise;
      logic [W-1:0] fall;
   } tpc_sync_st_t;

   tpc_sync_st_t r_ff;
   tpc_sync_st_t nxt_r;

   // ---------------------------------------------------------------
   // filter
   // ---------------------------------------------------------------
   always_comb
   begin
      nxt_r    = r_ff;
      nxt_r.s1 = PIN;
      nxt_r.s2 = r_ff.s1;
      nxt_r.s3 = r_ff.s2;
      // accept a level only once two later stages agree
      nxt_r.lvl  = (r_ff.s2 & r_ff.s3) | (r_ff.lvl & (r_ff.s2 | r_ff.s3));
      nxt_r.rise = nxt_r.lvl & ~r_ff.lvl;
      nxt_r.fall = ~nxt_r.lvl & r_ff.lvl;
   end

   always_ff @(posedge CLOCK)
   begin
      if (!RST_N)
         r_ff <= '0;
      else
         r_ff <= nxt_r;
   end

   assign LEVEL = r_ff.lvl;
   assign RISE  = r_ff.rise;
   assign FALL  = r_ff.fall;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_SYNC_ACCEPT: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (r_ff.s2[0] == r_ff.s3[0]) && (r_ff.s3[0] != r_ff.lvl[0])
      |=> (r_ff.lvl[0] != $past(r_ff.lvl[0])) && (RISE[0] || FALL[0]))
      else $error("agreed level not accepted");

endmodule

//--- tb/tpc_pin_env.sv
// outside world of the timer pins: pulse sources, pin resolution, count clock
// assumes a 100 ns bus clock; pins are resolved here from the enables
module tpc_pin_env
   import tpc_pkg::*;
(
   input  wire logic [tpc_pkg::NCH-1:0] CH_OUT,
   input  wire logic [tpc_pkg::NCH-1:0] CH_OE,
   output logic      [tpc_pkg::NCH-1:0] CH_IN,
   output logic                         EXT_CLK
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [NCH-1:0] src;

   // ---------------------------------------------------------------
   // pin resolution
   // ---------------------------------------------------------------
   // a driven pin shows the timer level, else the outside source
   always_comb
      for (int i = 0; i < NCH; i++)
         CH_IN[i] = (CH_OE[i] === 1'b1) ? CH_OUT[i] : src[i];

   initial
   begin
      src     = '0;
      EXT_CLK = 1'b0;
   end

   // ---------------------------------------------------------------
   // sources
   // ---------------------------------------------------------------
   // count clock on its own pin, never a channel pin in use
   // period 500 ns keeps it below bus rate / 4, idle low between runs
   task automatic ext_pulses(input int cnt);
      #37;
      repeat (cnt)
      begin
         #250 EXT_CLK = 1'b1;
         #250 EXT_CLK = 1'b0;
      end
   endtask

   // pulse width given in bus cycles, off the bus clock phase
   task automatic cap_pulse(input int ch, input int cyc);
      #43 src[ch] = 1'b1;
      #(cyc * CLK_NS) src[ch] = 1'b0;
   endtask
endmodule

//--- tb/testbench.sv
// self-checking bench for the timer channel pin logic
// assumes tpc_pin_env as the pin world and a 10 MHz bus clock
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
`define WAIT(c) begin n = 0; while (!(c) && n < 40) begin tick(); n++; \
   end if (n >= 40) begin mismatches++; finish_test(); end end

module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import tpc_pkg::*;

   logic            CLOCK = 1'b0;
   logic            RST_N = 1'b0;
   logic [AW-1:0]   ADDR = '0;
   logic [DW-1:0]   WDATA = '0;
   logic            WR = 1'b0;
   logic            RD = 1'b0;
   logic [DW-1:0]   RDATA;
   logic            FIXED_TICK = 1'b0;
   logic            EXT_CLK;
   logic [NCH-1:0]  CH_IN;
   logic [NCH-1:0]  CH_OUT;
   logic [NCH-1:0]  CH_OE;
   logic [NCH-1:0]  CH_OWN;
   logic            OVERFLOW;
   int              mismatches = 0;
   int              compares = 0;
   int              n;
   logic [DW-1:0]   d;

   always #50 CLOCK = ~CLOCK;

   tpc_timer_pins tpc_timer_pins_i (
      .CLOCK(CLOCK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .FIXED_TICK(FIXED_TICK), .EXT_CLK(EXT_CLK),
      .CH_IN(CH_IN), .CH_OUT(CH_OUT), .CH_OE(CH_OE), .CH_OWN(CH_OWN),
      .OVERFLOW(OVERFLOW));

   tpc_pin_env tpc_pin_env_i (
      .CH_OUT(CH_OUT), .CH_OE(CH_OE), .CH_IN(CH_IN), .EXT_CLK(EXT_CLK));

   // ---------------------------------------------------------------
   // bus and helpers
   // ---------------------------------------------------------------
   task automatic finish_test();
      if (mismatches == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic tick();
      @(posedge CLOCK);
      #1;
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
      @(posedge CLOCK);
      ADDR  <= a;
      WDATA <= v;
      WR    <= 1'b1;
      @(posedge CLOCK);
      WR    <= 1'b0;
   endtask

   // read data only stands in the cycle after the strobe
   task automatic rd(input logic [AW-1:0] a);
      @(posedge CLOCK);
      ADDR <= a;
      RD   <= 1'b1;
      @(posedge CLOCK);
      RD   <= 1'b0;
      #1;
      d = RDATA;
   endtask

   function automatic logic [DW-1:0] scv(input logic c, input logic [1:0] k);
      return (DW'(c) << SC_CPWM_BIT) | (DW'(k) << SC_CLKS_LSB);
   endfunction

   function automatic logic [DW-1:0] ctv(input logic [1:0] m,
                                         input logic [1:0] e);
      return (DW'(m) << CS_MODE_LSB) | (DW'(e) << CS_ELS_LSB);
   endfunction

   function automatic logic [AW-1:0] cha(input int ch, input int v);
      return AW'(int'(ADR_CH0) + CH_STEP * ch + v);
   endfunction

   // cycles that channel 0 stays at one level
   task automatic run_len(input logic lvl);
      n = 0;
      while (CH_OUT[0] === lvl && n < 40)
      begin
         tick();
         n++;
      end
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      tick();
      `CHK(CH_OWN, 2'h0)
      `CHK(CH_OE, 2'h0)
      `CHK(OVERFLOW, 1'b0)
      wr(8'hFF, 16'hFFFF);
      rd(8'hFF);
      `CHK(d, 16'h0000)
      rd(ADR_SC);
      `CHK(d, 16'h0000)
   endtask

   task automatic t_edge_pwm();
      wr(ADR_SC, '0);
      wr(ADR_MOD, 16'h0008);
      wr(cha(0, 1), 16'h0005);
      wr(cha(1, 1), 16'h0005);
      wr(cha(0, 0), ctv(2'h2, ELS_CLR));
      wr(cha(1, 0), ctv(2'h2, ELS_TOG));
      wr(ADR_CNT, '0);
      wr(ADR_SC, scv(1'b0, CLK_BUS));
      `WAIT(CH_OUT[0] === 1'b0)
      `WAIT(CH_OUT[0] === 1'b1)
      `CHK(CH_OUT, 2'h1)
      `CHK(CH_OE, 2'h3)
      run_len(1'b1);
      `CHK(n, 5)
      `CHK(CH_OUT, 2'h2)
      run_len(1'b0);
      `CHK(n, 4)
      rd(ADR_SC);
      `CHK(d[SC_OVF_BIT], 1'b1)
   endtask

   // mode 00 left on purpose: center select must override it
   task automatic t_center_pwm();
      wr(ADR_SC, '0);
      wr(cha(0, 0), ctv(MODE_CAP, ELS_CLR));
      wr(cha(1, 0), ctv(MODE_CAP, ELS_TOG));
      wr(ADR_CNT, '0);
      wr(ADR_SC, scv(1'b1, CLK_BUS));
      `WAIT(CH_OUT[0] === 1'b0)
      `WAIT(CH_OUT[0] === 1'b1)
      `CHK(CH_OUT, 2'h1)
      `CHK(CH_OE, 2'h3)
      run_len(1'b1);
      `CHK(n, 10)
      `CHK(CH_OUT, 2'h2)
      run_len(1'b0);
      `CHK(n, 6)
   endtask

   task automatic t_mid_reset();
      @(posedge CLOCK);
      RST_N <= 1'b0;
      repeat (3) @(posedge CLOCK);
      RST_N <= 1'b1;
      tick();
      `CHK(CH_OWN, 2'h0)
      `CHK(CH_OE, 2'h0)
      `CHK(OVERFLOW, 1'b0)
   endtask

   task automatic t_compare();
      wr(ADR_MOD, 16'h0008);
      wr(cha(0, 1), 16'h0003);
      wr(cha(0, 0), ctv(MODE_CMP, ELS_SET));
      wr(ADR_SC, scv(1'b0, CLK_BUS));
      `WAIT(CH_OUT[0] === 1'b1)
      `CHK(CH_OE[0], 1'b1)
      wr(cha(0, 0), ctv(MODE_CMP, ELS_CLR));
      `WAIT(CH_OUT[0] === 1'b0)
      wr(cha(0, 0), ctv(MODE_CMP, ELS_SET));
      `WAIT(CH_OUT[0] === 1'b1)
      wr(cha(0, 0), ctv(MODE_CMP, ELS_TOG));
      tick();
      `CHK(CH_OUT[0], 1'b1)
      `WAIT(CH_OUT[0] === 1'b0)
      run_len(1'b0);
      `CHK(n, 9)
      wr(cha(0, 0), ctv(MODE_CMP, ELS_OFF));
      tick();
      `CHK(CH_OWN[0], 1'b0)
      wr(cha(0, 0), ctv(MODE_CMP, ELS_CLR));
      wr(ADR_SC, scv(1'b0, CLK_NONE));
      tick();
      `CHK(CH_OWN[0], 1'b0)
   endtask

   task automatic t_clock_src();
      wr(ADR_MOD, '0);
      wr(cha(0, 0), '0);
      wr(cha(1, 1), 16'h0005);
      wr(cha(1, 0), ctv(MODE_CMP, ELS_OFF));
      wr(ADR_CNT, '0);
      tpc_pin_env_i.ext_pulses(3);
      rd(ADR_CNT);
      `CHK(d, 16'h0000)
      wr(ADR_SC, scv(1'b0, CLK_EXT));
      tpc_pin_env_i.ext_pulses(10);
      repeat (8) tick();
      rd(ADR_CNT);
      `CHK(d, 16'h000A)
      `CHK(CH_OWN[1], 1'b0)
      rd(cha(1, 0));
      `CHK(d[CS_FLAG_BIT], 1'b1)
      wr(ADR_SC, scv(1'b0, CLK_FIXED));
      wr(ADR_CNT, '0);
      repeat (7)
      begin
         @(posedge CLOCK);
         FIXED_TICK <= 1'b1;
         @(posedge CLOCK);
         FIXED_TICK <= 1'b0;
      end
      rd(ADR_CNT);
      `CHK(d, 16'h0007)
   endtask

   // pin not owned first: that pulse must leave the flag clear
   task automatic t_capture();
      wr(ADR_SC, scv(1'b0, CLK_BUS));
      rd(cha(0, 0));
      wr(cha(0, 0), ctv(MODE_CAP, ELS_OFF));
      tpc_pin_env_i.cap_pulse(0, MIN_PULSE_CYC);
      repeat (8) tick();
      rd(cha(0, 0));
      `CHK(d[CS_FLAG_BIT], 1'b0)
      wr(cha(0, 0), ctv(MODE_CAP, ELS_SET));
      tick();
      `CHK(CH_OWN[0], 1'b1)
      `CHK(CH_OE[0], 1'b0)
      tpc_pin_env_i.cap_pulse(0, MIN_PULSE_CYC);
      repeat (8) tick();
      rd(cha(0, 0));
      `CHK(d[CS_FLAG_BIT], 1'b1)
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (3) @(posedge CLOCK);
      RST_N <= 1'b1;
      t_reset();
      t_edge_pwm();
      t_center_pwm();
      t_mid_reset();
      t_compare();
      t_clock_src();
      t_capture();
      finish_test();
   end
endmodule
